/* hdl/mmd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mmd_defs.svh"
// Behaviour
// - program store 8192 words, 0x0000 to 0x1fff
// - instruction pointer is thirteen bits wide
// - working registers at 0x0000 to 0x001f
// - io file at 0x0020 to 0x005f
// - short io address is data address minus 0x20
// - bit operations only on short 0x00..0x1f
// - extended io 0x0060-0x00ff, long access only
// - sram 1024 bytes at 0x0100 to 0x04ff
// - direct mode uses 16-bit second word
// - displacement: x, y or z plus 0..63
// - pre-decrement pointer then access
// - post-increment: access then bump pointer
// - pointers live in registers 26 to 31
// - every mode but short io reaches all volatile locations; short io reaches only 0x0020 to 0x005f
// - each data access takes two cycles
// - three scratch io registers, bit capable
module mmd_decoder
    import mmd_pkg::*;
#(
    parameter int PROG_WORDS = `MMD_PROG_WORDS,
    parameter int SRAM_BYTES = `MMD_SRAM_BYTES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ip_load,
    input wire logic [12:0] ip_value,
    input wire logic ip_step,
    input wire logic [15:0] prog_wdata,
    input wire logic prog_we,
    output logic [12:0] instruction_pointer,
    output logic [15:0] fetch_word,
    input wire logic req_valid,
    input wire mmd_req_t req,
    output logic busy,
    output logic done,
    output logic [7:0] rdata,
    output logic skip_if_io_bit_set,
    output logic bit_refused,
    output logic [15:0] eff_addr,
    output logic wr_strobe,
    output logic rd_strobe,
    output logic [1:0] region,
    output logic [7:0] scratch_io_0,
    output logic [7:0] scratch_io_1,
    output logic [7:0] scratch_io_2
);
    logic [15:0] prog_mem [0:PROG_WORDS-1];
    logic [7:0] gpr [0:31];
    logic [7:0] io_file [0:63];
    logic [7:0] ext_file [0:159];
    logic [7:0] sram [0:SRAM_BYTES-1];
    mmd_state_t state;
    mmd_req_t cur;
    logic [15:0] next_addr;
    logic [15:0] ptr_val;
    logic [15:0] ptr_new;
    logic ptr_upd;
    logic [7:0] rd_byte;
    logic [7:0] wr_byte;
    logic [7:0] bitmask;
    logic bit_ok;
    logic [4:0] ptr_lo;
    logic bit_write;
    logic store_en;

    // region decode of a data address
    function automatic mmd_region_t region_of(input logic [15:0] a);
        if (a <= `MMD_GPR_LAST) begin
            region_of = MMD_R_GPR;
        end else if (a <= `MMD_IO_LAST) begin
            region_of = MMD_R_IO;
        end else if (a <= `MMD_EXT_LAST) begin
            region_of = MMD_R_EXT;
        end else begin
            region_of = MMD_R_SRAM;
        end
    endfunction

    // byte read from the unified data space
    function automatic logic [7:0] read_at(input logic [15:0] a);
        if (a > `MMD_SRAM_LAST) begin
            read_at = 8'h00;
        end else begin
            case (region_of(a))
                MMD_R_GPR: read_at = gpr[a[4:0]];
                MMD_R_IO: read_at = io_file[6'(a - `MMD_IO_BASE)];
                MMD_R_EXT: read_at = ext_file[8'(a - `MMD_EXT_BASE)];
                MMD_R_SRAM: read_at = sram[10'(a - `MMD_SRAM_BASE)];
                default: read_at = 8'h00;
            endcase
        end
    endfunction

    // program store fetch at the instruction pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instruction_pointer <= 13'h0000;
        end else if (ip_load) begin
            instruction_pointer <= ip_value;
        end else if (ip_step) begin
            instruction_pointer <= instruction_pointer + 13'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (prog_we) begin
            prog_mem[instruction_pointer] <= prog_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_word <= 16'h0000;
        end else begin
            fetch_word <= prog_mem[instruction_pointer];
        end
    end

    // selected pointer from register pairs 26..31
    always_comb begin
        case (req.ptr)
            2'h0: ptr_lo = `MMD_PTR_X;
            2'h1: ptr_lo = `MMD_PTR_Y;
            default: ptr_lo = `MMD_PTR_Z;
        endcase
        ptr_val = {gpr[ptr_lo + 5'h01], gpr[ptr_lo]};
    end

    // effective address formed in the address cycle
    always_comb begin
        next_addr = req.addr;
        ptr_new = ptr_val;
        ptr_upd = 1'b0;
        case (req.mode)
            MMD_DIRECT: next_addr = req.addr;
            MMD_INDIRECT: next_addr = ptr_val;
            MMD_DISP: next_addr = ptr_val + {10'h000, req.disp};
            MMD_PREDEC: begin
                ptr_new = ptr_val - 16'h0001;
                next_addr = ptr_new;
                ptr_upd = 1'b1;
            end
            MMD_POSTINC: begin
                next_addr = ptr_val;
                ptr_new = ptr_val + 16'h0001;
                ptr_upd = 1'b1;
            end
            MMD_IOSHORT: next_addr = {10'h000, req.addr[5:0]} + `MMD_IO_BASE;
            default: next_addr = req.addr;
        endcase
    end

    // two-cycle access sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= MMD_ST_ADDR;
            cur <= '0;
            eff_addr <= 16'h0000;
            region <= MMD_R_GPR;
        end else begin
            case (state)
                MMD_ST_ADDR: begin
                    if (req_valid) begin
                        state <= MMD_ST_DATA;
                        cur <= req;
                        eff_addr <= next_addr;
                        region <= region_of(next_addr);
                    end
                end
                MMD_ST_DATA: state <= MMD_ST_ADDR;
                default: state <= MMD_ST_ADDR;
            endcase
        end
    end

    // bit operations allowed only in the low io half
    always_comb begin
        bit_ok = (cur.mode == MMD_IOSHORT) && (cur.addr[5:0] <= `MMD_IO_BIT_LAST);
        bitmask = 8'h01 << cur.bitsel;
        rd_byte = read_at(eff_addr);
        case (cur.bitop)
            MMD_BIT_SET: wr_byte = rd_byte | bitmask;
            MMD_BIT_CLR: wr_byte = rd_byte & ~bitmask;
            default: wr_byte = cur.wdata;
        endcase
    end

    // a store lands for plain writes and accepted set or clear, never above the map
    always_comb begin
        bit_write = bit_ok && (cur.bitop == MMD_BIT_SET || cur.bitop == MMD_BIT_CLR);
        store_en = (cur.wr && cur.bitop == MMD_BIT_NONE) || bit_write;
        if (eff_addr > `MMD_SRAM_LAST) begin
            store_en = 1'b0;
        end
    end

    // data cycle: strobes, read data, skip result
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            wr_strobe <= 1'b0;
            rd_strobe <= 1'b0;
            skip_if_io_bit_set <= 1'b0;
            bit_refused <= 1'b0;
        end else begin
            busy <= (state == MMD_ST_ADDR) && req_valid;
            done <= (state == MMD_ST_DATA);
            wr_strobe <= (state == MMD_ST_ADDR) && req_valid && req.wr;
            rd_strobe <= (state == MMD_ST_ADDR) && req_valid && !req.wr;
            skip_if_io_bit_set <= 1'b0;
            bit_refused <= 1'b0;
            if (state == MMD_ST_DATA) begin
                rdata <= rd_byte;
                if (cur.bitop != MMD_BIT_NONE) begin
                    bit_refused <= !bit_ok;
                    skip_if_io_bit_set <= bit_ok && (cur.bitop == MMD_BIT_TEST)
                        && ((rd_byte & bitmask) != 8'h00);
                end
            end
        end
    end

    // storage writes in the data cycle, pointer update in the address cycle
    always_ff @(posedge clk) begin
        if (state == MMD_ST_DATA) begin
            if (store_en) begin
                case (region_of(eff_addr))
                    MMD_R_GPR: gpr[eff_addr[4:0]] <= wr_byte;
                    MMD_R_IO: io_file[6'(eff_addr - `MMD_IO_BASE)] <= wr_byte;
                    MMD_R_EXT: ext_file[8'(eff_addr - `MMD_EXT_BASE)] <= wr_byte;
                    MMD_R_SRAM: sram[10'(eff_addr - `MMD_SRAM_BASE)] <= wr_byte;
                    default: ;
                endcase
            end
        end else if (state == MMD_ST_ADDR && req_valid && ptr_upd) begin
            gpr[ptr_lo] <= ptr_new[7:0];
            gpr[ptr_lo + 5'h01] <= ptr_new[15:8];
        end
    end

    // scratch io registers mirrored out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scratch_io_0 <= 8'h00;
            scratch_io_1 <= 8'h00;
            scratch_io_2 <= 8'h00;
        end else begin
            scratch_io_0 <= io_file[`MMD_SCRATCH0];
            scratch_io_1 <= io_file[`MMD_SCRATCH1];
            scratch_io_2 <= io_file[`MMD_SCRATCH2];
        end
    end

    // access timing and strobe checks
    AST_TWO_CYCLE: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid) |=> state == MMD_ST_DATA ##1 done)
        else $error("access not two cycles");
    AST_STROBE_WR: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && req.wr) |=> wr_strobe && !rd_strobe)
        else $error("write strobe missing");
    AST_STROBE_RD: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && !req.wr) |=> rd_strobe && !wr_strobe)
        else $error("read strobe missing");
    AST_STROBE_BUSY: assert property (@(posedge clk) disable iff (rst)
        (wr_strobe || rd_strobe) |-> busy)
        else $error("strobe outside data cycle");
    AST_DATA_IDLE: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_DATA) |=> !busy && !wr_strobe && !rd_strobe)
        else $error("request taken in data cycle");
    AST_DONE_PULSE: assert property (@(posedge clk) disable iff (rst)
        done |=> !done)
        else $error("done longer than one cycle");
    AST_EFF_HOLD: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_DATA) |=> $stable(eff_addr))
        else $error("address moved in data cycle");

    // address formation checks
    AST_SHORT_IO: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && req.mode == MMD_IOSHORT)
        |=> eff_addr == {10'h000, $past(req.addr[5:0])} + 16'h0020)
        else $error("short io address wrong");
    AST_DIRECT: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && req.mode == MMD_DIRECT)
        |=> eff_addr == $past(req.addr))
        else $error("direct address wrong");
    AST_PREDEC: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && req.mode == MMD_PREDEC)
        |=> eff_addr == $past(ptr_val) - 16'h0001)
        else $error("pre-decrement address wrong");
    AST_POSTINC: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && req.mode == MMD_POSTINC)
        |=> eff_addr == $past(ptr_val))
        else $error("post-increment address wrong");
    AST_DISP: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && req.mode == MMD_DISP)
        |=> eff_addr == $past(ptr_val) + {10'h000, $past(req.disp)})
        else $error("displacement address wrong");

    // region decode checks
    AST_REGION_GPR: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && next_addr <= `MMD_GPR_LAST)
        |=> region == MMD_R_GPR)
        else $error("working register region wrong");
    AST_REGION_IO: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && next_addr >= `MMD_IO_BASE
        && next_addr <= `MMD_IO_LAST) |=> region == MMD_R_IO)
        else $error("io region wrong");
    AST_REGION_EXT: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && next_addr > `MMD_IO_LAST
        && next_addr <= `MMD_EXT_LAST) |=> region == MMD_R_EXT)
        else $error("extended io region wrong");
    AST_REGION_SRAM: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_ADDR && req_valid && next_addr >= `MMD_SRAM_BASE)
        |=> region == MMD_R_SRAM)
        else $error("sram region wrong");
    AST_HIGH_ZERO: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_DATA && eff_addr > 16'h04ff) |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // bit operation checks
    AST_BIT_RANGE: assert property (@(posedge clk) disable iff (rst)
        skip_if_io_bit_set |-> $past(cur.addr[5:0]) <= 6'h1f)
        else $error("bit op outside low io");
    AST_SKIP_ONLY_TEST: assert property (@(posedge clk) disable iff (rst)
        skip_if_io_bit_set |-> $past(cur.bitop) == MMD_BIT_TEST)
        else $error("skip without bit test");
    AST_SKIP_VALUE: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_DATA && cur.bitop == MMD_BIT_TEST && bit_ok)
        |=> skip_if_io_bit_set == $past(rd_byte[cur.bitsel]))
        else $error("bit test result wrong");
    AST_REFUSE_FLAG: assert property (@(posedge clk) disable iff (rst)
        (state == MMD_ST_DATA && cur.bitop != MMD_BIT_NONE && !bit_ok) |=> bit_refused)
        else $error("bit op not refused");
    AST_REFUSED_NO_SKIP: assert property (@(posedge clk) disable iff (rst)
        bit_refused |-> !skip_if_io_bit_set)
        else $error("refused op reported skip");

    // fetch pointer checks
    AST_IP_LOAD: assert property (@(posedge clk) disable iff (rst)
        ip_load |=> instruction_pointer == $past(ip_value))
        else $error("pointer load wrong");
    AST_IP_STEP: assert property (@(posedge clk) disable iff (rst)
        (!ip_load && ip_step)
        |=> instruction_pointer == $past(instruction_pointer) + 13'h0001)
        else $error("pointer step wrong");

    CV_WRITE: cover property (@(posedge clk) disable iff (rst) wr_strobe ##1 done);
    CV_SKIP: cover property (@(posedge clk) disable iff (rst) skip_if_io_bit_set);
    CV_SRAM: cover property (@(posedge clk) disable iff (rst) rd_strobe && region == MMD_R_SRAM);
    CV_REFUSE: cover property (@(posedge clk) disable iff (rst) bit_refused);
    CV_PTR_UPDATE: cover property (@(posedge clk) disable iff (rst)
        state == MMD_ST_ADDR && req_valid && ptr_upd);
endmodule // mmd_decoder
`default_nettype wire

/* hdl/mmd_defs.svh */
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH
`define MMD_PROG_WORDS 8192
`define MMD_PROG_LAST 13'h1fff
`define MMD_IP_W 13
`define MMD_GPR_LAST 16'h001f
`define MMD_IO_BASE 16'h0020
`define MMD_IO_LAST 16'h005f
`define MMD_IO_SHORT_LAST 6'h3f
`define MMD_IO_BIT_LAST 6'h1f
`define MMD_EXT_LAST 16'h00ff
`define MMD_EXT_BASE 16'h0060
`define MMD_SRAM_BASE 16'h0100
`define MMD_SRAM_LAST 16'h04ff
`define MMD_SRAM_BYTES 1024
`define MMD_PTR_X 5'h1a
`define MMD_PTR_Y 5'h1c
`define MMD_PTR_Z 5'h1e
`define MMD_DISP_MAX 6'h3f
`define MMD_SCRATCH0 6'h1e
`define MMD_SCRATCH1 6'h0a
`define MMD_SCRATCH2 6'h0b
`endif

/* hdl/mmd_pkg.sv */
`default_nettype none
package mmd_pkg;
    typedef enum logic [2:0] {
        MMD_DIRECT = 3'h0,
        MMD_INDIRECT = 3'h1,
        MMD_DISP = 3'h2,
        MMD_PREDEC = 3'h3,
        MMD_POSTINC = 3'h4,
        MMD_IOSHORT = 3'h5
    } mmd_mode_t;
    typedef enum logic [1:0] {
        MMD_R_GPR = 2'h0,
        MMD_R_IO = 2'h1,
        MMD_R_EXT = 2'h2,
        MMD_R_SRAM = 2'h3
    } mmd_region_t;
    typedef enum logic [1:0] {
        MMD_BIT_NONE = 2'h0,
        MMD_BIT_SET = 2'h1,
        MMD_BIT_CLR = 2'h2,
        MMD_BIT_TEST = 2'h3
    } mmd_bitop_t;
    typedef struct packed {
        mmd_mode_t mode;
        mmd_bitop_t bitop;
        logic wr;
        logic [1:0] ptr;
        logic [15:0] addr;
        logic [5:0] disp;
        logic [2:0] bitsel;
        logic [7:0] wdata;
    } mmd_req_t;
    typedef enum logic {
        MMD_ST_ADDR = 1'b0,
        MMD_ST_DATA = 1'b1
    } mmd_state_t;
endpackage
`default_nettype wire

/* tb/mmd_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// core side of the block: issues one access and gathers the answer
module mmd_core_model
    import mmd_pkg::*;
(
    input wire logic clk,
    input wire logic busy,
    input wire logic done,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [7:0] rdata,
    input wire logic skip_if_io_bit_set,
    input wire logic bit_refused,
    input wire logic [15:0] eff_addr,
    input wire logic [1:0] region,
    output logic req_valid,
    output mmd_req_t req
);
    // idle request lines from time zero
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // one access: take edge, address cycle, data cycle; released lines scrambled
    task automatic access(input mmd_req_t r, output logic [7:0] d, output logic [15:0] ea,
                          output logic [1:0] rg, output logic [5:0] fl);
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req = r;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        req = ~r;
        ea = eff_addr;
        rg = region;
        fl[5:3] = {busy, wr_strobe, rd_strobe};
        @(posedge clk);
        #1;
        d = rdata;
        fl[2:0] = {done, skip_if_io_bit_set, bit_refused};
    endtask
endmodule // mmd_core_model
`default_nettype wire

/* tb/mmd_decoder_test.sv */
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_test
    import mmd_pkg::*;
;
    logic clk, rst, ip_load, ip_step, prog_we, req_valid, busy, done, skip, refused;
    logic wr_strobe, rd_strobe;
    logic [12:0] ip_value, instruction_pointer;
    logic [15:0] prog_wdata, fetch_word, eff_addr, ea;
    logic [7:0] rdata, rd, s0, s1, s2;
    logic [1:0] region, rg;
    logic [5:0] fl;
    mmd_req_t req;
    int errors = 0;
    int comparisons = 0;

    mmd_decoder uut (.clk(clk), .rst(rst), .ip_load(ip_load), .ip_value(ip_value),
        .ip_step(ip_step), .prog_wdata(prog_wdata), .prog_we(prog_we),
        .instruction_pointer(instruction_pointer), .fetch_word(fetch_word),
        .req_valid(req_valid), .req(req), .busy(busy), .done(done), .rdata(rdata),
        .skip_if_io_bit_set(skip), .bit_refused(refused), .eff_addr(eff_addr),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .region(region),
        .scratch_io_0(s0), .scratch_io_1(s1), .scratch_io_2(s2));

    mmd_core_model core (.clk(clk), .busy(busy), .done(done), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rdata(rdata), .skip_if_io_bit_set(skip),
        .bit_refused(refused), .eff_addr(eff_addr), .region(region),
        .req_valid(req_valid), .req(req));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input mmd_mode_t m, input mmd_bitop_t b, input logic w,
                       input logic [1:0] p, input logic [15:0] a, input logic [5:0] ds,
                       input logic [2:0] bs, input logic [7:0] wd);
        mmd_req_t r;
        r = '{mode: m, bitop: b, wr: w, ptr: p, addr: a, disp: ds, bitsel: bs, wdata: wd};
        core.access(r, rd, ea, rg, fl);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc(MMD_DIRECT, MMD_BIT_NONE, 1'b1, 2'h0, a, 6'h00, 3'h0, d);
    endtask

    task automatic rdd(input logic [15:0] a);
        acc(MMD_DIRECT, MMD_BIT_NONE, 1'b0, 2'h0, a, 6'h00, 3'h0, 8'h00);
    endtask

    // let the one-cycle-late copies settle
    task automatic step1;
        @(posedge clk);
        #1;
    endtask

    task automatic t_prog;
        chk("reset pointer", 16'h0000, 16'(instruction_pointer));
        chk("reset outputs", 16'h0000, {12'h000, busy, done, wr_strobe, rd_strobe});
        ip_load = 1'b1;
        ip_step = 1'b1;
        ip_value = 13'h1fff;
        step1();
        chk("pointer load", 16'h1fff, 16'(instruction_pointer));
        ip_load = 1'b0;
        ip_step = 1'b0;
        prog_we = 1'b1;
        prog_wdata = 16'hbeef;
        step1();
        prog_we = 1'b0;
        step1();
        chk("fetch word", 16'hbeef, fetch_word);
        ip_step = 1'b1;
        step1();
        ip_step = 1'b0;
        chk("pointer wrap", 16'h0000, 16'(instruction_pointer));
        $display("program store test done");
    endtask

    task automatic t_regions;
        logic [15:0] a[8];
        a = '{16'h0000, 16'h001f, 16'h0020, 16'h005f, 16'h0060, 16'h00ff, 16'h0100, 16'h04ff};
        for (int i = 0; i < 8; i++) begin
            wr(a[i], 8'h5a ^ 8'(i));
            chk("write flags", 16'h0034, 16'(fl));
            chk("region", 16'(i / 2), 16'(rg));
            rdd(a[i]);
            chk("read flags", 16'h002c, 16'(fl));
            chk("read address", a[i], ea);
            chk("read data", 16'h005a ^ 16'(i), 16'(rd));
        end
        wr(16'h0500, 8'ha5);
        rdd(16'h0500);
        chk("beyond top", 16'h0000, 16'(rd));
        rdd(16'h0100);
        chk("no alias", 16'h005c, 16'(rd));
        $display("region test done");
    endtask

    task automatic t_io;
        acc(MMD_IOSHORT, MMD_BIT_NONE, 1'b1, 2'h0, 16'h003f, 6'h00, 3'h0, 8'hc3);
        chk("short address", 16'h005f, ea);
        rdd(16'h005f);
        chk("short data", 16'h00c3, 16'(rd));
        acc(MMD_IOSHORT, MMD_BIT_NONE, 1'b1, 2'h0, 16'h001e, 6'h00, 3'h0, 8'h81);
        wr(16'h002b, 8'h42);
        step1();
        chk("scratch 0", 16'h0081, 16'(s0));
        chk("scratch 2", 16'h0042, 16'(s2));
        $display("io test done");
    endtask

    task automatic t_bits;
        wr(16'h002a, 8'h00);
        acc(MMD_IOSHORT, MMD_BIT_SET, 1'b0, 2'h0, 16'h000a, 6'h00, 3'h3, 8'h00);
        step1();
        chk("bit set", 16'h0008, 16'(s1));
        acc(MMD_IOSHORT, MMD_BIT_TEST, 1'b0, 2'h0, 16'h000a, 6'h00, 3'h3, 8'h00);
        chk("test set", 16'h0002, 16'(fl[1:0]));
        acc(MMD_IOSHORT, MMD_BIT_CLR, 1'b0, 2'h0, 16'h000a, 6'h00, 3'h3, 8'h00);
        step1();
        chk("bit clear", 16'h0000, 16'(s1));
        acc(MMD_IOSHORT, MMD_BIT_TEST, 1'b0, 2'h0, 16'h000a, 6'h00, 3'h3, 8'h00);
        chk("test clear", 16'h0000, 16'(fl[1:0]));
        wr(16'h0040, 8'h00);
        acc(MMD_IOSHORT, MMD_BIT_SET, 1'b0, 2'h0, 16'h0020, 6'h00, 3'h0, 8'h00);
        chk("upper refused", 16'h0001, 16'(fl[0]));
        acc(MMD_DIRECT, MMD_BIT_SET, 1'b0, 2'h0, 16'h0040, 6'h00, 3'h0, 8'h00);
        chk("long refused", 16'h0001, 16'(fl[0]));
        rdd(16'h0040);
        chk("no write", 16'h0000, 16'(rd));
        $display("bit test done");
    endtask

    task automatic t_ptr;
        wr(16'h001a, 8'h20);
        wr(16'h001b, 8'h01);
        acc(MMD_POSTINC, MMD_BIT_NONE, 1'b1, 2'h0, 16'h0000, 6'h00, 3'h0, 8'h77);
        chk("post address", 16'h0120, ea);
        rdd(16'h001a);
        chk("post pointer", 16'h0021, 16'(rd));
        acc(MMD_PREDEC, MMD_BIT_NONE, 1'b0, 2'h0, 16'h0000, 6'h00, 3'h0, 8'h00);
        chk("pre address", 16'h0120, ea);
        chk("pre data", 16'h0077, 16'(rd));
        wr(16'h001c, 8'h00);
        wr(16'h001d, 8'h01);
        acc(MMD_DISP, MMD_BIT_NONE, 1'b0, 2'h1, 16'h0000, 6'h3f, 3'h0, 8'h00);
        chk("disp address", 16'h013f, ea);
        wr(16'h001e, 8'h05);
        wr(16'h001f, 8'h00);
        acc(MMD_INDIRECT, MMD_BIT_NONE, 1'b1, 2'h2, 16'h0000, 6'h00, 3'h0, 8'h99);
        rdd(16'h0005);
        chk("indirect reg", 16'h0099, 16'(rd));
        $display("pointer test done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        ip_load = 1'b0;
        ip_step = 1'b0;
        ip_value = 13'h0000;
        prog_we = 1'b0;
        prog_wdata = 16'h0000;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        t_prog();
        t_regions();
        t_io();
        t_bits();
        t_ptr();
        print_verdict();
    end

    // watchdog well beyond the 145 or so cycles the scenarios need
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule // mmd_decoder_test
`default_nettype wire
